/* File: common/rtchp_pkg.sv */
package rtchp_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam int          NUM_REGS        = 16;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
  localparam int          BANK_SEL_BIT    = 3;
  localparam int          CLK_HZ          = 10000000;
  localparam int          REC_MIN_MS      = 40;
  localparam int          REC_MAX_MS      = 200;
  // least time rounds up; whole ms divide exactly at this rate
  localparam int          REC_MIN_CYCLES  = REC_MIN_MS * (CLK_HZ / 1000);
  localparam int          REC_MAX_CYCLES  = REC_MAX_MS * (CLK_HZ / 1000);
endpackage : rtchp_pkg

/* File: rtl/rtchp_power_supervisor.sv */
`timescale 1ns/10ps
module rtchp_power_supervisor #(
  parameter int REC_CYCLES = rtchp_pkg::REC_MIN_CYCLES
) (
  input  wire logic clk,          // system clock
  input  wire logic sys_rst,      // async reset, active high
  input  wire logic supply_ok,    // high while supply above power_fail_threshold
  output logic      access_block, // high while access and ram enables are inhibited
  output logic      rst_out_n     // reset to the host, active low
);
  localparam int CNT_W = $clog2(REC_CYCLES + 1);

  logic [CNT_W-1:0] rec_count;
  logic             recovered;

  // count restarts on every dip, so a glitchy supply never releases early
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rec_count <= '0;
    end
    else if (!supply_ok)
    begin
      rec_count <= '0;
    end
    else if (!recovered)
    begin
      rec_count <= rec_count + CNT_W'(1);
    end
  end

  assign recovered = (rec_count == CNT_W'(REC_CYCLES));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      access_block <= 1'b1;
      rst_out_n    <= 1'b0;
    end
    else
    begin
      access_block <= !(supply_ok && recovered);
      rst_out_n    <= supply_ok && recovered;
    end
  end
endmodule : rtchp_power_supervisor

/* File: rtl/rtchp_host_port.sv */
`timescale 1ns/10ps
module rtchp_host_port #(
  parameter int REC_CYCLES = rtchp_pkg::REC_MIN_CYCLES
) (
  input  wire logic                          clk,                 // 10 MHz clock
  input  wire logic                          sys_rst,             // async reset, high
  input  wire logic                          reg_chip_enable_n,   // register enable, low
  input  wire logic                          write_enable_n,      // write strobe, low
  input  wire logic                          output_enable_n,     // output enable, low
  input  wire logic                          ext_mem_enable_n,    // external sram enable
  input  wire logic [rtchp_pkg::ADDR_W-1:0]  reg_addr,            // register address
  input  wire logic [rtchp_pkg::DATA_W-1:0]  data_bus_in,         // data bus, input side
  output logic      [rtchp_pkg::DATA_W-1:0]  data_bus_out,        // data bus, output side
  output logic                               data_bus_oe,         // high while driving
  input  wire logic                          supply_ok,           // supply in tolerance
  output logic                               cond_ram_enable_a_n, // sram bank a enable
  output logic                               cond_ram_enable_b_n, // sram bank b enable
  output logic                               rst_out_n            // host reset, low
);
  logic                             access_block;
  logic                             ce_gated;
  logic                             write_now;
  logic                             write_prev;
  logic                             read_now;
  logic                             fell_together;
  logic                             ce_prev_n;
  logic                             we_prev_n;
  logic                             hold_off;
  logic [rtchp_pkg::ADDR_W-1:0]     wr_addr;
  logic [rtchp_pkg::DATA_W-1:0]     wr_data;
  logic [rtchp_pkg::DATA_W-1:0]     regs [rtchp_pkg::NUM_REGS];
  logic                             wr_commit;

  rtchp_power_supervisor #(
    .REC_CYCLES (REC_CYCLES)
  ) u_supervisor (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .supply_ok    (supply_ok),
    .access_block (access_block),
    .rst_out_n    (rst_out_n)
  );

  // chip enable is gated off from the clock after the supply goes bad until one clock after recovery ends
  assign ce_gated  = !reg_chip_enable_n && !access_block;
  assign write_now = ce_gated && !write_enable_n;
  assign read_now  = ce_gated && write_enable_n;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      write_prev <= 1'b0;
    end
    else
    begin
      write_prev <= write_now;
    end
  end

  // enable history for the joint-fall test; resets to the idle pin level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ce_prev_n <= 1'b1;
      we_prev_n <= 1'b1;
    end
    else
    begin
      ce_prev_n <= reg_chip_enable_n;
      we_prev_n <= write_enable_n;
    end
  end

  // both enables dropping in one sample: this access never drives the bus
  assign fell_together = ce_prev_n && we_prev_n && !reg_chip_enable_n && !write_enable_n;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_off <= 1'b0;
    end
    else if (reg_chip_enable_n)
    begin
      hold_off <= 1'b0;
    end
    else if (fell_together)
    begin
      hold_off <= 1'b1;
    end
  end

  // address latched at the later falling edge; host keeps it stable anyway
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_addr <= '0;
    end
    else if (write_now && !write_prev)
    begin
      wr_addr <= reg_addr;
    end
  end

  // data sampled every write cycle; the last sample before the end is kept
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_data <= '0;
    end
    else if (write_now)
    begin
      wr_data <= data_bus_in;
    end
  end

  // end of write at the earlier rising edge; a power-fail abort stores nothing
  assign wr_commit = write_prev && !write_now && !access_block;

  generate
    for (genvar i = 0; i < rtchp_pkg::NUM_REGS; i++)
    begin : g_reg
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          regs[i] <= rtchp_pkg::REG_RESET_VAL;
        end
        else if (wr_commit && (wr_addr == rtchp_pkg::ADDR_W'(i)))
        begin
          regs[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_bus_out <= '0;
    end
    else
    begin
      data_bus_out <= regs[reg_addr];
    end
  end

  // strobe low removes drive at once, even mid-read; external select wins
  assign data_bus_oe = read_now && !output_enable_n && ext_mem_enable_n
                       && !hold_off;

  // bank select stays combinational so sram sees no extra clock of delay
  assign cond_ram_enable_a_n = ext_mem_enable_n || reg_addr[rtchp_pkg::BANK_SEL_BIT]
                               || access_block;
  assign cond_ram_enable_b_n = ext_mem_enable_n || !reg_addr[rtchp_pkg::BANK_SEL_BIT]
                               || access_block;
endmodule : rtchp_host_port

/* File: testbench/rtchp_props.sv */
`timescale 1ns/10ps
module rtchp_props #(
  parameter int REC_CYCLES = rtchp_pkg::REC_MIN_CYCLES
) (
  input wire logic       clk,                 // clk
  input wire logic       sys_rst,             // rst
  input wire logic       reg_chip_enable_n,   // ce
  input wire logic       write_enable_n,      // we
  input wire logic       output_enable_n,     // oe
  input wire logic       ext_mem_enable_n,    // ext
  input wire logic [3:0] reg_addr,            // addr
  input wire logic [7:0] data_bus_in,         // din
  input wire logic [7:0] data_bus_out,        // dout
  input wire logic       data_bus_oe,         // drive
  input wire logic       supply_ok,           // supply
  input wire logic       cond_ram_enable_a_n, // bank a
  input wire logic       cond_ram_enable_b_n, // bank b
  input wire logic       rst_out_n            // reset
);
  int ok_cnt;
  // edges of unbroken good supply
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      ok_cnt <= 0;
    else
      ok_cnt <= supply_ok ? ok_cnt + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_end_s;
    (rst_out_n && !reg_chip_enable_n && !write_enable_n) ##1
      (rst_out_n && write_enable_n && $stable(reg_addr)) ##1 (rst_out_n && $stable(reg_addr));
  endsequence
  sequence both_fall_s;
    ($fell(reg_chip_enable_n) && $fell(write_enable_n)) ##1 (write_enable_n && !reg_chip_enable_n);
  endsequence
  bank_a_sel_a: assert property (
    cond_ram_enable_a_n == (ext_mem_enable_n | reg_addr[3] | !rst_out_n)) else $error("bank a");
  bank_b_sel_a: assert property (
    cond_ram_enable_b_n == (ext_mem_enable_n | !reg_addr[3] | !rst_out_n)) else $error("bank b");
  write_off_a: assert property (!write_enable_n |-> !data_bus_oe) else $error("oe in write");
  ext_off_a: assert property (!ext_mem_enable_n |-> !data_bus_oe) else $error("oe ext");
  drive_cond_a: assert property (data_bus_oe |-> !reg_chip_enable_n && !output_enable_n
    && rst_out_n) else $error("oe cause");
  wr_data_a: assert property (wr_end_s |=> data_bus_out == $past(data_bus_in, 3))
    else $error("write data");
  rec_time_a: assert property ($rose(rst_out_n) |-> ok_cnt == REC_CYCLES + 1)
    else $error("recovery time");
  fail_rst_a: assert property (!supply_ok |=> !rst_out_n) else $error("fail reset");
  same_fall_a: assert property (both_fall_s |-> !data_bus_oe) else $error("joint fall");
endmodule : rtchp_props

/* File: testbench/rtchp_host_model.sv */
`timescale 1ns/10ps
module rtchp_host_model (
  input  wire logic       clk,   // clk
  input  wire logic [7:0] dq_in, // device data
  input  wire logic       dq_oe, // device drives
  output logic            ce_n,  // ce
  output logic            we_n,  // we
  output logic            oe_n,  // oe
  output logic            ext_n, // ext
  output logic [3:0]      addr,  // addr
  output logic [7:0]      dq_out // data
);
  initial
  begin
    {ce_n, we_n, oe_n, ext_n, addr, dq_out} = 16'hf05a;
  end
  task wr(input logic [3:0] a, input logic [7:0] d, input logic hold);
    @(posedge clk);
    #1 {ce_n, we_n, oe_n, addr, dq_out} = {3'b001, a, d};
    @(posedge clk);
    // inverted byte so a late sample never sees stale data
    #1 {ce_n, we_n, oe_n, dq_out} = {~hold, 1'b1, ~hold, ~d};
    if (hold)
      @(posedge clk) #1 {ce_n, oe_n} = 2'b11;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    #1 {ce_n, oe_n, addr} = {2'b00, a};
    repeat (2) @(posedge clk);
    #1 d = dq_in;
    oe = dq_oe;
    {ce_n, oe_n} = 2'b11;
  endtask : rd
  // read with outputs on, then the strobe falls while enable stays low
  task rdwr(input logic [3:0] a, input logic [7:0] d, output logic oe_rd, output logic oe_wr);
    @(posedge clk);
    #1 {ce_n, we_n, oe_n, addr} = {3'b010, a};
    @(posedge clk);
    #1 oe_rd = dq_oe;
    {we_n, dq_out} = {1'b0, d};
    #1 oe_wr = dq_oe;
    @(posedge clk);
    #1 {ce_n, we_n, oe_n} = 3'b111;
  endtask : rdwr
  task sel(input logic e, w, input logic [3:0] a);
    @(posedge clk);
    #1 {ext_n, we_n, addr} = {e, w, a};
  endtask : sel
endmodule : rtchp_host_model

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic       clk, sys_rst, supply_ok, ce_n, we_n, oe_n, ext_n, doe, ca_n, cb_n, rst_n, o, o2;
  logic [3:0] addr;
  logic [7:0] din, dout, d;
  logic [7:0] mem [16];
  int         n_errors, total_checks, seed, cyc;
  rtchp_host_port #(.REC_CYCLES(20)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_chip_enable_n(ce_n), .write_enable_n(we_n), .output_enable_n(oe_n),
    .ext_mem_enable_n(ext_n), .reg_addr(addr), .data_bus_in(din), .data_bus_out(dout),
    .data_bus_oe(doe), .supply_ok(supply_ok), .cond_ram_enable_a_n(ca_n),
    .cond_ram_enable_b_n(cb_n), .rst_out_n(rst_n));
  rtchp_host_model i_host (.clk(clk), .dq_in(dout), .dq_oe(doe), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .ext_n(ext_n), .addr(addr), .dq_out(din));
  task chk(input string what, input logic [7:0] seen, expd);
    total_checks++;
    if (seen !== expd)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, expd, seen);
    end
  endtask : chk
  function automatic logic [1:0] bank_exp(input logic e, a3, ok);
    return {e | !a3 | !ok, e | a3 | !ok};
  endfunction : bank_exp
  task give_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task check_all();
    for (int i = 0; i < 16; i++)
    begin
      i_host.rd(i[3:0], d, o);
      chk("read data", d, mem[i]);
      chk("read oe", o, 8'h01);
    end
  endtask : check_all
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    seed = 32'h7a7d709a;
    {sys_rst, supply_ok} = 2'b10;
    repeat (3) @(posedge clk);
    #1 {sys_rst, supply_ok} = 2'b01;
    i_host.rd(4'h0, d, o);
    chk("early", {o, rst_n}, 8'h00);
    repeat (17) @(posedge clk);
    #1 chk("reset hold", rst_n, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("reset out", rst_n, 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = (i == 15) ? 8'hff : 8'($random(seed));
      i_host.wr(i[3:0], mem[i], i[0]);
    end
    check_all();
    for (int i = 0; i < 32; i++)
    begin
      i_host.sel(i[4], i[0], i[3:0]);
      #1 chk("banks", {doe, cb_n, ca_n}, {1'b0, bank_exp(i[4], i[3], 1'b1)});
    end
    mem[5] = 8'($random(seed));
    i_host.rdwr(4'h5, mem[5], o, o2);
    chk("oe before strobe", o, 8'h01);
    chk("oe after strobe", o2, 8'h00);
    i_host.sel(1'b1, 1'b1, 4'h0);
    supply_ok = 0;
    i_host.wr(4'h2, ~mem[2], 1'b0);
    i_host.sel(1'b0, 1'b1, 4'h8);
    #1 chk("blocked", {rst_n, cb_n, ca_n}, 3'b011);
    i_host.sel(1'b1, 1'b1, 4'h0);
    supply_ok = 1;
    repeat (25) @(posedge clk);
    check_all();
    give_verdict();
  end
endmodule : tb_top
bind rtchp_host_port rtchp_props #(.REC_CYCLES(REC_CYCLES)) i_props (.*);
